// File: rtl/pdm_defines.svh
// register offsets, field positions, reset values and cycle counts
`ifndef PDM_DEFINES_SVH
`define PDM_DEFINES_SVH
`define PDM_OFF_CTRL 8'h00
`define PDM_OFF_WPAGE 8'h04
`define PDM_OFF_TPAGE 8'h08
`define PDM_OFF_MSTART 8'h0c
`define PDM_OFF_MEND 8'h10
`define PDM_OFF_STAT 8'h14
`define PDM_CTRL_WIN_BIT 0
`define PDM_RST_PAGE 8'h00
`define PDM_RST_MSTART 16'h0000
`define PDM_RST_MEND 16'hfffe
`define PDM_RAM_END 16'h0fff
`define PDM_Y_BASE 16'h0800
`define PDM_Y_END 16'h0fff
`define PDM_EXTRA_NONE 2'h0
`define PDM_EXTRA_SHORT 2'h1
`define PDM_EXTRA_LONG 2'h2
`endif

// File: rtl/pdm_pkg.sv
// types shared by the access map modules
package pdm_pkg;
	typedef enum logic [2:0] {
		DATA_READ = 3'b000,
		DATA_WRITE = 3'b001,
		TABLE_READ_LOW = 3'b010,
		TABLE_READ_HIGH = 3'b011,
		TABLE_WRITE_LOW = 3'b100,
		TABLE_WRITE_HIGH = 3'b101
	} pdm_kind_type;
	typedef enum logic [1:0] {
		TGT_NONE = 2'b00,
		TGT_DATA = 2'b01,
		TGT_PROG = 2'b10
	} pdm_tgt_type;
	typedef enum logic {
		CLS_SHORT = 1'b0,
		CLS_LONG = 1'b1
	} pdm_cls_type;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_ISSUE = 2'b01,
		ST_DATA = 2'b10,
		ST_STALL = 2'b11
	} pdm_state_type;
endpackage

// File: rtl/pdm_map_if.sv
// request context, mapping decision and read formatting signals
`timescale 1ns/100ps
interface pdm_map_if;
	import pdm_pkg::*;
	pdm_kind_type kind;
	logic [15:0] ea;
	logic [15:0] y_ea;
	logic mac;
	logic win_en;
	logic [7:0] win_page;
	logic [7:0] tbl_page;
	logic tbl_busy;
	pdm_tgt_type tgt;
	logic [23:0] prog_addr;
	logic x_ok;
	logic y_ok;
	pdm_kind_type f_kind;
	logic f_byte;
	logic f_sel;
	pdm_tgt_type f_tgt;
	logic f_xok;
	logic f_yok;
	logic [23:0] prog_rdata;
	logic [15:0] dmem_rdata;
	logic [15:0] ymem_rdata;
	logic [15:0] xdata;
	logic [15:0] ydata;
	modport ctrl(output kind, ea, y_ea, mac, win_en, win_page, tbl_page, tbl_busy,
		f_kind, f_byte, f_sel, f_tgt, f_xok, f_yok, prog_rdata, dmem_rdata, ymem_rdata,
		input tgt, prog_addr, x_ok, y_ok, xdata, ydata);
	modport mapper(input kind, ea, y_ea, mac, win_en, win_page, tbl_page, tbl_busy,
		output tgt, prog_addr, x_ok, y_ok);
	modport fmt(input f_kind, f_byte, f_sel, f_tgt, f_xok, f_yok, prog_rdata,
		dmem_rdata, ymem_rdata, output xdata, ydata);
endinterface // pdm_map_if

// File: rtl/pdm_addr_map.sv
// address decode: data ram, program window, table space, x/y split
`timescale 1ns/100ps
`include "pdm_defines.svh"
module pdm_addr_map import pdm_pkg::*; #(
	parameter logic [15:0] RAM_END = `PDM_RAM_END,
	parameter logic [15:0] Y_BASE = `PDM_Y_BASE,
	parameter logic [15:0] Y_END = `PDM_Y_END
) (
	pdm_map_if.mapper m
);
	function automatic logic in_y(input logic [15:0] a);
		return (a >= Y_BASE) && (a <= Y_END);
	endfunction

	logic is_data;
	logic win_hit;

	always_comb begin
		is_data = (m.kind == DATA_READ) || (m.kind == DATA_WRITE);
		win_hit = is_data && m.ea[15] && m.win_en && !m.tbl_busy;
		m.tgt = TGT_NONE;
		m.prog_addr = 24'h00_0000;
		if (!is_data) begin
			m.tgt = TGT_PROG;
			m.prog_addr = {m.tbl_page, m.ea[15:1], 1'b0};
		end else if (win_hit) begin
			m.prog_addr = {1'b0, m.win_page, m.ea[14:1], 1'b0};
			// window is read only; writes are dropped
			m.tgt = (m.kind == DATA_READ) ? TGT_PROG : TGT_NONE;
		end else if (m.ea <= RAM_END) begin
			m.tgt = TGT_DATA;
		end
		m.x_ok = !(m.mac && (m.kind == DATA_READ) && in_y(m.ea));
		m.y_ok = m.mac && (m.kind == DATA_READ) && in_y(m.y_ea);
	end
endmodule // pdm_addr_map

// File: rtl/pdm_rd_fmt.sv
// shapes program and data words into the 16-bit read results
`timescale 1ns/100ps
module pdm_rd_fmt import pdm_pkg::*; (
	pdm_map_if.fmt f
);
	function automatic logic [7:0] pick(input logic [15:0] w, input logic sel);
		return sel ? w[15:8] : w[7:0];
	endfunction

	logic [15:0] word;

	always_comb begin
		word = 16'h0000;
		f.xdata = 16'h0000;
		f.ydata = 16'h0000;
		case (f.f_kind)
			TABLE_READ_LOW: f.xdata = f.f_byte ? {8'h00, pick(f.prog_rdata[15:0], f.f_sel)}
				: f.prog_rdata[15:0];
			TABLE_READ_HIGH: f.xdata = {8'h00, (f.f_byte && f.f_sel) ? 8'h00
				: f.prog_rdata[23:16]};
			DATA_READ: begin
				if (f.f_tgt == TGT_PROG) word = f.prog_rdata[15:0];
				else if (f.f_tgt == TGT_DATA) word = f.dmem_rdata;
				if (!f.f_xok) word = 16'h0000;
				f.xdata = f.f_byte ? {8'h00, pick(word, f.f_sel)} : word;
			end
			default: f.xdata = 16'h0000;
		endcase
		if (f.f_yok) f.ydata = f.ymem_rdata;
	end
endmodule // pdm_rd_fmt

// File: rtl/pdm_access_map.sv
// access map between core data paths, program memory and x/y data ram
// Functional notes
// - low table word read returns program bits 15..0 unchanged
// - low table byte read: select 0 gives bits 7..0, 1 gives 15..8
// - high table word read: bits 23..16 into low byte, high byte zero
// - high table byte read: select 0 gives bits 23..16, 1 gives zero
// - program address steps two per word: low and high spaces
// - upper 32 Kbyte data half maps onto any 16K-word program page
// - window only when ea msb set and window enable set
// - window returns low 16 program bits, upper 8 ignored
// - window address is page register above ea bits 14..1, bit 0 zero
// - window mapping suspended during table reads and writes
// - window outside repeat: short class one extra, others two
// - window in repeat: two extra at edges, else none
// - y block fixed inside x; mac x reads exclude it
// - mac fetches x and y operands together on own paths
// - all writes go on the x bus, never on y
// - modulo on x and y, bit reverse only on x writes
// - unimplemented or wrong-space mac fetch returns zero
// - data ea is 16-bit byte address, 64 Kbytes
// - table address upper bits come from table page register
// - ea lsb selects byte of the word
//
// Added by the designer: the register addresses and the Avalon-MM slave port.
`timescale 1ns/100ps
`include "pdm_defines.svh"
module pdm_access_map import pdm_pkg::*; #(
	parameter logic [15:0] RAM_END = `PDM_RAM_END,
	parameter logic [15:0] Y_BASE = `PDM_Y_BASE,
	parameter logic [15:0] Y_END = `PDM_Y_END,
	parameter int BREV_BITS = 8
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic req_valid,
	output logic req_ready,
	input wire pdm_kind_type req_kind,
	input wire logic req_byte,
	input wire logic req_mac,
	input wire pdm_cls_type req_cls,
	input wire logic [15:0] req_ea,
	input wire logic [15:0] req_y_ea,
	input wire logic req_mod,
	input wire logic req_brev,
	input wire logic [15:0] req_wdata,
	input wire logic req_rep,
	input wire logic req_rep_first,
	input wire logic req_rep_last,
	input wire logic req_rep_exit,
	input wire logic req_rep_reenter,
	output logic rsp_valid,
	output logic [15:0] rsp_data,
	output logic [15:0] rsp_ydata,
	output logic [15:0] dmem_addr,
	output logic dmem_rd,
	output logic dmem_wr,
	output logic [1:0] dmem_be,
	output logic [15:0] dmem_wdata,
	input wire logic [15:0] dmem_rdata,
	output logic [15:0] ymem_addr,
	output logic ymem_rd,
	input wire logic [15:0] ymem_rdata,
	output logic [23:0] prog_addr,
	output logic prog_rd,
	output logic prog_wr,
	output logic [2:0] prog_be,
	output logic [23:0] prog_wdata,
	input wire logic [23:0] prog_rdata
);
	function automatic logic [15:0] wrap(input logic [15:0] a, input logic [15:0] lo,
		input logic [15:0] hi);
		logic [15:0] span;
		span = hi - lo + 16'h0002;
		if (a > hi) return a - span;
		if (a < lo) return a + span;
		return a;
	endfunction

	function automatic logic [15:0] brev(input logic [15:0] a);
		logic [15:0] r;
		r = a;
		for (int i = 0; i < BREV_BITS; i++) r[i + 1] = a[BREV_BITS - i];
		return r;
	endfunction

	function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] wd,
		input logic [3:0] be);
		return {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
	endfunction

	function automatic logic [1:0] extra_cycles(input logic win, input pdm_cls_type cls,
		input logic rep, input logic edge_it);
		if (!win) return `PDM_EXTRA_NONE;
		if (!rep) return (cls == CLS_SHORT) ? `PDM_EXTRA_SHORT : `PDM_EXTRA_LONG;
		return edge_it ? `PDM_EXTRA_LONG : `PDM_EXTRA_NONE;
	endfunction

	pdm_map_if m();
	pdm_state_type state_q;
	logic [1:0] cnt_q;
	logic [1:0] extra_q;
	pdm_kind_type kind_q;
	logic byte_q;
	logic sel_q;
	pdm_tgt_type tgt_q;
	logic xok_q;
	logic yok_q;
	logic win_en_q;
	logic [7:0] win_page_q;
	logic [7:0] tbl_page_q;
	logic [15:0] mod_lo_q;
	logic [15:0] mod_hi_q;
	logic [15:0] hits_q;
	logic avs_waitrequest_q;
	logic [31:0] avs_readdata_q;
	logic accept;
	logic av_take;
	logic av_done;
	logic is_rd;
	logic is_wr;
	logic win_acc;
	logic rep_edge;
	logic [15:0] x_ea;
	logic [15:0] y_ea;
	logic [1:0] extra_d;
	logic finish;

	assign accept = req_valid && req_ready;
	assign is_rd = (req_kind == DATA_READ);
	assign is_wr = (req_kind == DATA_WRITE);
	assign rep_edge = req_rep_first || req_rep_last || req_rep_exit || req_rep_reenter;
	assign x_ea = (is_wr && req_brev) ? brev(req_mod ? wrap(req_ea, mod_lo_q, mod_hi_q)
		: req_ea) : (req_mod ? wrap(req_ea, mod_lo_q, mod_hi_q) : req_ea);
	assign y_ea = req_mod ? wrap(req_y_ea, mod_lo_q, mod_hi_q) : req_y_ea;
	assign win_acc = accept && is_rd && (m.tgt == TGT_PROG);
	assign extra_d = extra_cycles(win_acc, req_cls, req_rep, rep_edge);
	assign finish = ((state_q == ST_DATA) && (extra_q == `PDM_EXTRA_NONE))
		|| ((state_q == ST_STALL) && (cnt_q == 2'h1));

	assign m.kind = req_kind;
	assign m.ea = x_ea;
	assign m.y_ea = y_ea;
	assign m.mac = req_mac;
	assign m.win_en = win_en_q;
	assign m.win_page = win_page_q;
	assign m.tbl_page = tbl_page_q;
	// held while a table op runs
	assign m.tbl_busy = (state_q != ST_IDLE) && (kind_q != DATA_READ)
		&& (kind_q != DATA_WRITE);
	assign m.f_kind = kind_q;
	assign m.f_byte = byte_q;
	assign m.f_sel = sel_q;
	assign m.f_tgt = tgt_q;
	assign m.f_xok = xok_q;
	assign m.f_yok = yok_q;
	assign m.prog_rdata = prog_rdata;
	assign m.dmem_rdata = dmem_rdata;
	assign m.ymem_rdata = ymem_rdata;

	pdm_addr_map #(
		.RAM_END(RAM_END),
		.Y_BASE(Y_BASE),
		.Y_END(Y_END)
	) u_map (
		.m(m.mapper)
	);

	pdm_rd_fmt u_fmt (
		.f(m.fmt)
	);

	// avalon slave: waitrequest drops for one cycle per request
	assign av_take = (avs_read || avs_write) && avs_waitrequest_q;
	assign av_done = (avs_read || avs_write) && !avs_waitrequest_q;
	assign avs_waitrequest = avs_waitrequest_q;
	assign avs_readdata = avs_readdata_q;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			avs_waitrequest_q <= 1'b1;
			avs_readdata_q <= 32'h0000_0000;
		end else begin
			avs_waitrequest_q <= !av_take;
			if (av_take && avs_read) begin
				case (avs_address)
					`PDM_OFF_CTRL: avs_readdata_q <= {31'h0000_0000, win_en_q};
					`PDM_OFF_WPAGE: avs_readdata_q <= {24'h00_0000, win_page_q};
					`PDM_OFF_TPAGE: avs_readdata_q <= {24'h00_0000, tbl_page_q};
					`PDM_OFF_MSTART: avs_readdata_q <= {16'h0000, mod_lo_q};
					`PDM_OFF_MEND: avs_readdata_q <= {16'h0000, mod_hi_q};
					`PDM_OFF_STAT: avs_readdata_q <= {15'h0000, state_q != ST_IDLE, hits_q};
					default: avs_readdata_q <= 32'h0000_0000;
				endcase
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			win_en_q <= 1'b0;
			win_page_q <= `PDM_RST_PAGE;
			tbl_page_q <= `PDM_RST_PAGE;
			mod_lo_q <= `PDM_RST_MSTART;
			mod_hi_q <= `PDM_RST_MEND;
		end else if (av_done && avs_write) begin
			case (avs_address)
				`PDM_OFF_CTRL: if (avs_byteenable[0]) begin
					win_en_q <= avs_writedata[`PDM_CTRL_WIN_BIT];
				end
				`PDM_OFF_WPAGE: if (avs_byteenable[0]) begin
					win_page_q <= avs_writedata[7:0];
				end
				`PDM_OFF_TPAGE: if (avs_byteenable[0]) begin
					tbl_page_q <= avs_writedata[7:0];
				end
				`PDM_OFF_MSTART: mod_lo_q <= merge(mod_lo_q, avs_writedata, avs_byteenable);
				`PDM_OFF_MEND: mod_hi_q <= merge(mod_hi_q, avs_writedata, avs_byteenable);
				default: ;
			endcase
		end
	end

	// window hit counter, wraps silently
	always_ff @(posedge clk) begin
		if (!rst_n) hits_q <= 16'h0000;
		else if (win_acc) hits_q <= hits_q + 16'h0001;
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_q <= ST_IDLE;
			cnt_q <= 2'h0;
		end else begin
			case (state_q)
				ST_IDLE: if (accept) state_q <= ST_ISSUE;
				ST_ISSUE: state_q <= ST_DATA;
				ST_DATA: if (extra_q == `PDM_EXTRA_NONE) begin
					state_q <= ST_IDLE;
				end else begin
					state_q <= ST_STALL;
					cnt_q <= extra_q;
				end
				ST_STALL: begin
					cnt_q <= cnt_q - 2'h1;
					if (cnt_q == 2'h1) state_q <= ST_IDLE;
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	// ready falls on accept so one request is in flight at a time
	always_ff @(posedge clk) begin
		if (!rst_n) req_ready <= 1'b0;
		else req_ready <= ((state_q == ST_IDLE) && !accept) || finish;
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			kind_q <= DATA_READ;
			byte_q <= 1'b0;
			sel_q <= 1'b0;
			tgt_q <= TGT_NONE;
			xok_q <= 1'b0;
			yok_q <= 1'b0;
			extra_q <= `PDM_EXTRA_NONE;
		end else if (accept) begin
			kind_q <= req_kind;
			byte_q <= req_byte;
			sel_q <= x_ea[0];
			tgt_q <= m.tgt;
			xok_q <= m.x_ok;
			yok_q <= m.y_ok;
			extra_q <= extra_d;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			dmem_addr <= 16'h0000;
			dmem_rd <= 1'b0;
			dmem_wr <= 1'b0;
			dmem_be <= 2'b00;
			dmem_wdata <= 16'h0000;
			ymem_addr <= 16'h0000;
			ymem_rd <= 1'b0;
		end else begin
			dmem_rd <= 1'b0;
			dmem_wr <= 1'b0;
			ymem_rd <= 1'b0;
			if (accept && (m.tgt == TGT_DATA)) begin
				dmem_addr <= {x_ea[15:1], 1'b0};
				dmem_rd <= is_rd && m.x_ok;
				dmem_wr <= is_wr;
				dmem_be <= req_byte ? {x_ea[0], !x_ea[0]} : 2'b11;
				dmem_wdata <= req_byte ? {2{req_wdata[7:0]}} : req_wdata;
			end
			if (accept && m.y_ok) begin
				ymem_addr <= {y_ea[15:1], 1'b0};
				ymem_rd <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			prog_addr <= 24'h00_0000;
			prog_rd <= 1'b0;
			prog_wr <= 1'b0;
			prog_be <= 3'b000;
			prog_wdata <= 24'h00_0000;
		end else begin
			prog_rd <= 1'b0;
			prog_wr <= 1'b0;
			if (accept && (m.tgt == TGT_PROG)) begin
				prog_addr <= m.prog_addr;
				prog_rd <= (req_kind == DATA_READ) || (req_kind == TABLE_READ_LOW)
					|| (req_kind == TABLE_READ_HIGH);
				prog_wr <= (req_kind == TABLE_WRITE_LOW) || (req_kind == TABLE_WRITE_HIGH);
				// low space vs upper byte space
				if (req_kind == TABLE_WRITE_HIGH) begin
					prog_be <= (req_byte && x_ea[0]) ? 3'b000 : 3'b100;
					prog_wdata <= {req_wdata[7:0], 16'h0000};
				end else begin
					prog_be <= req_byte ? {1'b0, x_ea[0], !x_ea[0]} : 3'b011;
					prog_wdata <= {8'h00, req_byte ? {2{req_wdata[7:0]}} : req_wdata};
				end
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rsp_valid <= 1'b0;
			rsp_data <= 16'h0000;
			rsp_ydata <= 16'h0000;
		end else begin
			rsp_valid <= finish;
			if (state_q == ST_DATA) begin
				rsp_data <= m.xdata;
				rsp_ydata <= m.ydata;
			end
		end
	end

	property p_tbl_low_word;
		@(posedge clk) disable iff (!rst_n)
		(state_q == ST_DATA && kind_q == TABLE_READ_LOW && !byte_q)
		|=> rsp_data == $past(prog_rdata[15:0]);
	endproperty
	a_tbl_low_word: assert property (p_tbl_low_word) else $error("low word wrong");

	property p_tbl_low_byte;
		@(posedge clk) disable iff (!rst_n)
		(state_q == ST_DATA && kind_q == TABLE_READ_LOW && byte_q && sel_q)
		|=> rsp_data == {8'h00, $past(prog_rdata[15:8])};
	endproperty
	a_tbl_low_byte: assert property (p_tbl_low_byte) else $error("low byte wrong");

	property p_tbl_high_word;
		@(posedge clk) disable iff (!rst_n)
		(state_q == ST_DATA && kind_q == TABLE_READ_HIGH && !byte_q)
		|=> rsp_data == {8'h00, $past(prog_rdata[23:16])};
	endproperty
	a_tbl_high_word: assert property (p_tbl_high_word) else $error("high word wrong");

	property p_tbl_high_byte;
		@(posedge clk) disable iff (!rst_n)
		(state_q == ST_DATA && kind_q == TABLE_READ_HIGH && byte_q && sel_q)
		|=> rsp_data == 16'h0000;
	endproperty
	a_tbl_high_byte: assert property (p_tbl_high_byte) else $error("odd byte set");

	property p_win_gate;
		@(posedge clk) disable iff (!rst_n)
		(accept && is_rd && !win_en_q) |=> !prog_rd;
	endproperty
	a_win_gate: assert property (p_win_gate) else $error("window while off");

	property p_win_addr;
		@(posedge clk) disable iff (!rst_n)
		win_acc |=> prog_addr[22:15] == $past(win_page_q) && !prog_addr[23]
			&& prog_addr[14:1] == $past(x_ea[14:1]);
	endproperty
	a_win_addr: assert property (p_win_addr) else $error("window address wrong");

	property p_tbl_page;
		@(posedge clk) disable iff (!rst_n)
		(accept && req_kind == TABLE_READ_LOW) |=> prog_addr[23:16] == $past(tbl_page_q);
	endproperty
	a_tbl_page: assert property (p_tbl_page) else $error("table page unused");

	property p_stall_short;
		@(posedge clk) disable iff (!rst_n)
		(win_acc && !req_rep && req_cls == CLS_SHORT) |-> ##1 !rsp_valid[*3] ##1 rsp_valid;
	endproperty
	a_stall_short: assert property (p_stall_short) else $error("short stall wrong");

	property p_rep_mid;
		@(posedge clk) disable iff (!rst_n)
		(win_acc && req_rep && !rep_edge) |-> ##1 !rsp_valid[*2] ##1 rsp_valid;
	endproperty
	a_rep_mid: assert property (p_rep_mid) else $error("repeat middle stalled");

	property p_mac_zero;
		@(posedge clk) disable iff (!rst_n)
		(accept && req_mac && is_rd && !m.x_ok) |-> ##3 (rsp_valid && rsp_data == 16'h0000);
	endproperty
	a_mac_zero: assert property (p_mac_zero) else $error("wrong space not zero");
endmodule // pdm_access_map

// File: tb/pdm_mem_model.sv
// behavioural program flash and data ram beside the access map
`timescale 1ns/100ps
module pdm_mem_model (
	input wire logic clk,
	input wire logic [15:0] dmem_addr,
	input wire logic dmem_rd,
	input wire logic dmem_wr,
	input wire logic [1:0] dmem_be,
	input wire logic [15:0] dmem_wdata,
	output logic [15:0] dmem_rdata,
	input wire logic [15:0] ymem_addr,
	input wire logic ymem_rd,
	output logic [15:0] ymem_rdata,
	input wire logic [23:0] prog_addr,
	input wire logic prog_rd,
	input wire logic prog_wr,
	input wire logic [2:0] prog_be,
	input wire logic [23:0] prog_wdata,
	output logic [23:0] prog_rdata
);
	logic [15:0] dm [2048];
	logic [23:0] last_pa;
	logic [23:0] last_wa;
	logic [26:0] last_wd;
	function automatic logic [23:0] pw(input logic [23:0] a);
		return {a[8:1] ^ a[22:15], a[16:1] ^ {9'h000, a[23:17]}};
	endfunction
	function automatic logic [15:0] dw(input logic [15:0] a);
		return {a[11:1], 5'h15} ^ 16'ha000;
	endfunction
	initial begin
		{dmem_rdata, ymem_rdata, prog_rdata} = 56'h0;
		for (int i = 0; i < 2048; i++)
			dm[i] = dw(16'(i * 2));
	end
	// idle buses toggle so a late sample cannot match by luck
	always @(posedge clk) begin
		prog_rdata <= prog_rd ? pw(prog_addr) : ~prog_rdata;
		dmem_rdata <= dmem_rd ? dm[dmem_addr[11:1]] : ~dmem_rdata;
		ymem_rdata <= ymem_rd ? dm[ymem_addr[11:1]] : ~ymem_rdata;
		if (prog_rd)
			last_pa <= prog_addr;
		if (prog_wr) begin
			last_wa <= prog_addr;
			last_wd <= {prog_be, prog_wdata};
		end
		if (dmem_wr && dmem_be[0])
			dm[dmem_addr[11:1]][7:0] <= dmem_wdata[7:0];
		if (dmem_wr && dmem_be[1])
			dm[dmem_addr[11:1]][15:8] <= dmem_wdata[15:8];
	end
endmodule // pdm_mem_model

// File: tb/pdm_access_map_tb.sv
// random and corner tests of the access map against a memory model
`timescale 1ns/100ps
module pdm_access_map_tb;
	import pdm_pkg::*;
	logic clk = 1'b0, rst_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0, req_valid = 1'b0;
	logic [7:0] avs_address = 8'h00;
	logic [31:0] avs_writedata = 32'h0, avs_readdata;
	logic [3:0] avs_byteenable = 4'h3;
	logic avs_waitrequest, req_ready, rsp_valid, dmem_rd, dmem_wr, ymem_rd, prog_rd, prog_wr;
	pdm_kind_type req_kind = DATA_READ;
	pdm_cls_type req_cls = CLS_SHORT;
	logic req_byte = 1'b0, req_mac = 1'b0, req_mod = 1'b0, req_brev = 1'b0, req_rep = 1'b0;
	logic req_rep_first = 1'b0, req_rep_last = 1'b0, req_rep_exit = 1'b0, req_rep_reenter = 1'b0;
	logic [15:0] req_ea = 16'h0, req_y_ea = 16'h0, req_wdata = 16'h0;
	logic [15:0] rsp_data, rsp_ydata, dmem_addr, dmem_wdata, dmem_rdata, ymem_addr, ymem_rdata;
	logic [1:0] dmem_be;
	logic [2:0] prog_be;
	logic [23:0] prog_addr, prog_wdata, prog_rdata;
	int error_cnt = 0, checks = 0;
	pdm_access_map uut (.clk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
		.avs_byteenable, .avs_readdata, .avs_waitrequest, .req_valid, .req_ready, .req_kind,
		.req_byte, .req_mac, .req_cls, .req_ea, .req_y_ea, .req_mod, .req_brev, .req_wdata,
		.req_rep, .req_rep_first, .req_rep_last, .req_rep_exit, .req_rep_reenter, .rsp_valid,
		.rsp_data, .rsp_ydata, .dmem_addr, .dmem_rd, .dmem_wr, .dmem_be, .dmem_wdata,
		.dmem_rdata, .ymem_addr, .ymem_rd, .ymem_rdata, .prog_addr, .prog_rd, .prog_wr,
		.prog_be, .prog_wdata, .prog_rdata);
	pdm_mem_model mem (.clk, .dmem_addr, .dmem_rd, .dmem_wr, .dmem_be, .dmem_wdata,
		.dmem_rdata, .ymem_addr, .ymem_rd, .ymem_rdata, .prog_addr, .prog_rd, .prog_wr,
		.prog_be, .prog_wdata, .prog_rdata);
	always #50 clk = ~clk;
	// same fill patterns as the memory model
	function automatic logic [23:0] pw(input logic [23:0] a);
		return {a[8:1] ^ a[22:15], a[16:1] ^ {9'h000, a[23:17]}};
	endfunction
	function automatic logic [15:0] dw(input logic [15:0] a);
		return {a[11:1], 5'h15} ^ 16'ha000;
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= wd;
		avs_read <= !wr;
		avs_write <= wr;
		do @(posedge clk); while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	task automatic req(input pdm_kind_type k, input logic b, input logic [15:0] ea,
		input logic [15:0] wd, output logic [15:0] d, output logic [31:0] n);
		@(posedge clk);
		req_kind <= k;
		req_byte <= b;
		req_ea <= ea;
		req_wdata <= wd;
		req_valid <= 1'b1;
		do @(posedge clk); while (req_ready !== 1'b1);
		req_valid <= 1'b0;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (rsp_valid !== 1'b1);
		d = rsp_data;
	endtask
	function automatic logic [15:0] tbl_exp(input pdm_kind_type k, input logic b,
		input logic s, input logic [23:0] p);
		if (k == TABLE_READ_LOW)
			return b ? {8'h00, s ? p[15:8] : p[7:0]} : p[15:0];
		return (b && s) ? 16'h0 : {8'h00, p[23:16]};
	endfunction
	function automatic logic [31:0] win_lat(input logic c, input logic r, input logic [3:0] e);
		if (r)
			return (|e) ? 32'h5 : 32'h3;
		return c ? 32'h5 : 32'h4;
	endfunction
	task automatic summarize;
		$display("checks=%0d error_cnt=%0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		repeat (6000) @(posedge clk);
		error_cnt++;
		summarize();
	end
	initial begin
		logic [31:0] r, n;
		logic [15:0] d, ea, y, w;
		logic [23:0] pa;
		logic [7:0] tp, wp;
		logic [3:0] e;
		logic [26:0] wx;
		logic b, c;
		pdm_kind_type k;
		r = $urandom(2);
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		for (int i = 0; i < 6; i++) begin
			bus(1'b0, 8'(i * 4), 32'h0, r);
			chk(r, (i == 4) ? 32'h0000_fffe : 32'h0);
		end
		bus(1'b1, 8'h18, 32'hffff_ffff, r);
		bus(1'b0, 8'h18, 32'h0, r);
		chk(r, 32'h0);
		$display("registers done");
		tp = {1'b1, 7'($urandom)};
		wp = 8'($urandom);
		bus(1'b1, 8'h08, {24'h0, tp}, r);
		bus(1'b1, 8'h04, {24'h0, wp}, r);
		bus(1'b1, 8'h00, 32'h1, r);
		bus(1'b0, 8'h08, 32'h0, r);
		chk(r, {24'h0, tp});
		// window left on: table ops must bypass it
		for (int i = 0; i < 12; i++) begin
			k = i[0] ? TABLE_READ_HIGH : TABLE_READ_LOW;
			b = i[1];
			ea = 16'($urandom);
			req(k, b, ea, 16'h0, d, n);
			pa = {tp, ea[15:1], 1'b0};
			chk(d, tbl_exp(k, b, ea[0], pw(pa)));
			chk(mem.last_pa, pa);
			chk(n, 32'h3);
		end
		// table writes: low word, high word, odd low byte
		w = 16'($urandom);
		for (int i = 0; i < 3; i++) begin
			k = (i == 1) ? TABLE_WRITE_HIGH : TABLE_WRITE_LOW;
			ea = (i == 2) ? (16'($urandom) | 16'h0001) : (16'($urandom) & 16'hfffe);
			req(k, i == 2, ea, w, d, n);
			pa = {tp, ea[15:1], 1'b0};
			chk(mem.last_wa, pa);
			wx = (i == 0) ? {3'b011, 8'h00, w} : {3'b100, w[7:0], 16'h0000};
			if (i == 2) wx = {3'b010, 8'h00, w[7:0], w[7:0]};
			chk(mem.last_wd, wx);
		end
		$display("table done");
		for (int i = 0; i < 12; i++) begin
			c = 1'($urandom);
			b = 1'($urandom);
			e = (i < 4) ? 4'h0 : 4'($urandom);
			ea = 16'h8000 | 16'($urandom);
			req_cls <= pdm_cls_type'(c);
			req_rep <= i[0];
			{req_rep_first, req_rep_last, req_rep_exit, req_rep_reenter} <= e;
			req(DATA_READ, b, ea, 16'h0, d, n);
			pa = {1'b0, wp, ea[14:1], 1'b0};
			chk(d, tbl_exp(TABLE_READ_LOW, b, ea[0], pw(pa)));
			chk(mem.last_pa, pa);
			chk(n, win_lat(c, i[0], e));
		end
		req_rep <= 1'b0;
		{req_rep_first, req_rep_last, req_rep_exit, req_rep_reenter} <= 4'h0;
		bus(1'b1, 8'h00, 32'h0, r);
		for (int i = 0; i < 4; i++) begin
			ea = (i < 2) ? (16'h8000 | 16'($urandom)) : (16'h1000 + 16'($urandom % 28672));
			req(DATA_READ, 1'b0, ea, 16'h0, d, n);
			chk(d, 16'h0);
			chk(n, 32'h3);
		end
		// twelve window hits counted, none while disabled
		bus(1'b0, 8'h14, 32'h0, r);
		chk(r, 32'h0000_000c);
		$display("window done");
		for (int i = 0; i < 6; i++) begin
			ea = 16'($urandom) & 16'h03fe;
			w = 16'($urandom);
			y = 16'($urandom);
			req(DATA_WRITE, 1'b0, ea, w, d, n);
			req(DATA_WRITE, 1'b1, ea | 16'h1, {8'h00, y[7:0]}, d, n);
			req(DATA_READ, 1'b0, ea, 16'h0, d, n);
			chk(d, {y[7:0], w[7:0]});
			req(DATA_READ, 1'b1, ea | 16'h1, 16'h0, d, n);
			chk(d, {8'h00, y[7:0]});
		end
		$display("ram done");
		bus(1'b1, 8'h0c, 32'h0000_0400, r);
		bus(1'b1, 8'h10, 32'h0000_05fe, r);
		req_mod <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			ea = 16'h0600 + 16'(i * 130);
			req(DATA_READ, 1'b0, ea, 16'h0, d, n);
			chk(d, dw(ea - 16'h0200));
		end
		req_mod <= 1'b0;
		// reversed write lands at 0x0100; reads are never reversed
		w = 16'($urandom);
		req_brev <= 1'b1;
		req(DATA_WRITE, 1'b0, 16'h0002, w, d, n);
		req(DATA_READ, 1'b0, 16'h0100, 16'h0, d, n);
		req_brev <= 1'b0;
		chk(d, w);
		$display("modulo done");
		req_mac <= 1'b1;
		for (int i = 0; i < 8; i++) begin
			ea = 16'h0400 + (16'($urandom % 3072) & 16'hfffe);
			y = 16'h0400 + (16'($urandom % 3072) & 16'hfffe);
			req_y_ea <= y;
			req(DATA_READ, 1'b0, ea, 16'h0, d, n);
			chk(d, ea[11] ? 16'h0 : dw(ea));
			chk(rsp_ydata, y[11] ? dw(y) : 16'h0);
		end
		w = 16'($urandom);
		req(DATA_WRITE, 1'b0, 16'h0a00, w, d, n);
		req_mac <= 1'b0;
		req(DATA_READ, 1'b0, 16'h0a00, 16'h0, d, n);
		chk(d, w);
		$display("dual fetch done");
		summarize();
	end
endmodule // pdm_access_map_tb
